// ---- design/lpsc_pkg.sv ----
package lpsc_pkg;
  // bus address and register map
  localparam logic [6:0] SLAVE_ADDR = 7'h44;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_DATA_LO = 8'h02;
  localparam logic [7:0] REG_DATA_HI = 8'h03;
  localparam logic [7:0] REG_TLO_LO = 8'h04;
  localparam logic [7:0] REG_TLO_HI = 8'h05;
  localparam logic [7:0] REG_THI_LO = 8'h06;
  localparam logic [7:0] REG_THI_HI = 8'h07;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] TLO_RST = 8'h00;
  localparam logic [7:0] THI_RST = 8'hFF;
  // host-writable bits of the mode byte; the flag and bits 4:3 are not
  localparam logic [7:0] MODE_WMASK = 8'hE3;
  // field positions
  localparam int MODE_LSB = 5;
  localparam int FLAG_BIT = 2;
  localparam int PRST_LSB = 0;
  localparam int SCHEME_BIT = 7;
  localparam int FREQ_BIT = 6;
  localparam int AMP_LSB = 4;
  localparam int RES_LSB = 2;
  localparam int RANGE_LSB = 0;
  // led modulation timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MOD_KHZ = 360;
  localparam int unsigned MOD_HALF_CYC = (CLK_MHZ * 1000) / (2 * MOD_KHZ);
  localparam int MOD_W = 9;
  localparam logic [4:0] PERSIST_SAT = 5'h10;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, ALS_ONCE = 3'h1, IR_ONCE = 3'h2, PROX_ONCE = 3'h3,
    MODE_RSVD = 3'h4, ALS_CONT = 3'h5, IR_CONT = 3'h6, PROX_CONT = 3'h7
  } lpsc_mode_t;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
    I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
  } lpsc_i2c_st_t;

  // result mask for the selected resolution code
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    case (res)
      2'h0: return 16'hFFFF;
      2'h1: return 16'h0FFF;
      2'h2: return 16'h00FF;
      default: return 16'h000F;
    endcase
  endfunction

  // index of the sign bit for the selected resolution code
  function automatic logic [3:0] res_msb(input logic [1:0] res);
    case (res)
      2'h0: return 4'hF;
      2'h1: return 4'hB;
      2'h2: return 4'h7;
      default: return 4'h3;
    endcase
  endfunction

  // out-of-window conversions needed before the flag sets
  function automatic logic [4:0] persist_cycles(input logic [1:0] p);
    case (p)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  function automatic logic mode_active(input logic [2:0] m);
    return (m != MODE_OFF) && (m != MODE_RSVD);
  endfunction
endpackage

// ---- design/lpsc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser; the output moves only once stages two and three agree
module lpsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lpsc_sync_t;

  lpsc_sync_t sync_ff;
  lpsc_sync_t nxt_sync;

  // stage one feeds stage two only
  always_comb begin
    nxt_sync = sync_ff;
    nxt_sync.s1 = d_in;
    nxt_sync.s2 = sync_ff.s1;
    nxt_sync.s3 = sync_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_ff.s2[i] == sync_ff.s3[i]) begin
        nxt_sync.q[i] = sync_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign q_out = sync_ff.q;
endmodule
`default_nettype wire

// ---- design/lpsc_top.sv ----
// Summary of operation
// - after reset the device is powered down and all result bytes are zero
// - one-shot mode converts once, returns to power-down, keeps the result
// - continuous modes convert back to back, overwriting the result
// - writing power-down stops continuous conversion
// - integration counts 2^n oscillator cycles, n being 4, 8, 12 or 16
// - light and infrared results are unsigned, masked to the selected width
// - proximity sensing drives the led with programmed amplitude and modulation
// - open-drain active-low interrupt pin plus a readable status flag
// - flag when the result is above the high or below the low threshold
// - persistence setting delays the flag over several conversions, up to 16
// - four ranges, range 1 lowest full scale, range 4 highest
// - mode byte top bits choose the mode; low bits 00 mean one conversion
// - mode 111 is continuous proximity; persistence code 01 means four
// - config byte holds scheme, modulation, drive, resolution and range
// - multi-byte writes store successive bytes at successive addresses
// - ambient-rejecting proximity compares thresholds as signed values
// - flag and pin stay set until a transfer touching the mode byte ends
// - answer only to the seven-bit address 1000100
// - flag only after m consecutive out-of-window conversions
`timescale 1ns/10ps
`default_nettype none
module lpsc_top
  import lpsc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic osc_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [15:0] adc_data_in,
  output logic sda_out_out,
  output logic sda_oe_n_out,
  output logic int_out_out,
  output logic int_oe_n_out,
  output logic ir_led_drive_out,
  output logic [1:0] ir_led_amp_out,
  output logic [1:0] sense_range_out,
  output logic adc_integrate_out
);
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    lpsc_i2c_st_t st;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic touch0;
    logic sda_oe_n;
    logic scl_q;
    logic sda_q;
    logic busy;
    logic req_tgl;
    logic done_q;
    logic [2:0] conv_mode;
    logic [1:0] conv_res;
    logic [4:0] pcnt;
    logic [MOD_W-1:0] mod_cnt;
    logic mod_ph;
    logic ir_drv;
    logic int_oe_n;
    logic zero;
  } lpsc_sys_t;

  typedef struct packed {
    logic req_q;
    logic run;
    logic [15:0] cnt;
    logic [1:0] res;
    logic done_tgl;
    logic [15:0] result;
  } lpsc_osc_t;

  logic [1:0] rst_sys_ff;
  logic [1:0] rst_osc_ff;
  lpsc_sys_t sys_ff;
  lpsc_sys_t nxt_sys;
  lpsc_osc_t osc_ff;
  lpsc_osc_t nxt_osc;
  logic [2:0] sys_s;
  logic req_s;
  logic rst_ok;
  logic rst_osc_ok;
  logic scl_s;
  logic sda_s;
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;
  logic ev_done_w;
  logic wr0_w;
  logic set_w;

  // reset release, two flops per domain
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sys_ff <= 2'h0;
    end else begin
      rst_sys_ff <= {rst_sys_ff[0], 1'b1};
    end
  end

  always_ff @(posedge osc_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_osc_ff <= 2'h0;
    end else begin
      rst_osc_ff <= {rst_osc_ff[0], 1'b1};
    end
  end

  assign rst_ok = rst_sys_ff[1];
  assign rst_osc_ok = rst_osc_ff[1];

  // bus pins and the conversion-done toggle share one synchroniser
  lpsc_sync #(.W(3)) u_sys_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_ok),
    .d_in({scl_in, sda_in, osc_ff.done_tgl}),
    .q_out(sys_s)
  );

  lpsc_sync #(.W(1)) u_osc_sync (
    .clk_in(osc_clk_in),
    .rst_n_in(rst_osc_ok),
    .d_in(sys_ff.req_tgl),
    .q_out(req_s)
  );

  // bus conditions seen on the synchronised pins
  assign scl_s = sys_s[2];
  assign sda_s = sys_s[1];
  assign scl_rise_w = scl_s && !sys_ff.scl_q;
  assign scl_fall_w = !scl_s && sys_ff.scl_q;
  assign start_w = scl_s && sys_ff.scl_q && sys_ff.sda_q && !sda_s;
  assign stop_w = scl_s && sys_ff.scl_q && !sys_ff.sda_q && sda_s;
  assign ev_done_w = sys_s[0] != sys_ff.done_q;

  // register reads; unmapped addresses read as zero
  function automatic logic [7:0] rd_reg(input lpsc_sys_t s, input logic [7:0] a);
    return (a < 8'(NUM_REGS)) ? s.regs[a[2:0]] : 8'h00;
  endfunction

  // slave protocol, conversion sequencing, thresholds and led drive
  always_comb begin
    logic load;
    logic out_win;
    logic sgn;
    logic [15:0] val;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [4:0] pc;
    load = 1'b0;
    out_win = 1'b0;
    sgn = 1'b0;
    val = 16'h0000;
    thr_lo = 16'h0000;
    thr_hi = 16'h0000;
    pc = 5'h00;
    nxt_sys = sys_ff;
    wr0_w = 1'b0;
    set_w = 1'b0;
    nxt_sys.scl_q = scl_s;
    nxt_sys.sda_q = sda_s;
    nxt_sys.zero = 1'b0;
    if (start_w) begin
      nxt_sys.st = I2C_ADDR;
      nxt_sys.bitcnt = 4'h0;
      nxt_sys.sda_oe_n = 1'b1;
    end else if (stop_w) begin
      nxt_sys.st = I2C_IDLE;
      nxt_sys.sda_oe_n = 1'b1;
      nxt_sys.touch0 = 1'b0;
      if (sys_ff.touch0) begin
        nxt_sys.regs[REG_MODE][FLAG_BIT] = 1'b0;
      end
    end else begin
      if (scl_rise_w) begin
        if (sys_ff.st inside {I2C_ADDR, I2C_PTR, I2C_WR, I2C_RD}) begin
          nxt_sys.bitcnt = 4'(sys_ff.bitcnt + 4'h1);
        end
        if (sys_ff.st inside {I2C_ADDR, I2C_PTR, I2C_WR}) begin
          nxt_sys.shift = {sys_ff.shift[6:0], sda_s};
        end
        if (sys_ff.st == I2C_RD_ACK) begin
          nxt_sys.nack = sda_s;
        end
      end
      if (scl_fall_w) begin
        unique case (sys_ff.st)
          I2C_ADDR: if (sys_ff.bitcnt == 4'h8) begin
            nxt_sys.bitcnt = 4'h0;
            if (sys_ff.shift[7:1] == SLAVE_ADDR) begin
              nxt_sys.rw = sys_ff.shift[0];
              nxt_sys.sda_oe_n = 1'b0;
              nxt_sys.st = I2C_ADDR_ACK;
            end else begin
              nxt_sys.st = I2C_IDLE;
            end
          end
          I2C_PTR: if (sys_ff.bitcnt == 4'h8) begin
            nxt_sys.bitcnt = 4'h0;
            nxt_sys.ptr = sys_ff.shift;
            nxt_sys.sda_oe_n = 1'b0;
            nxt_sys.st = I2C_PTR_ACK;
          end
          I2C_WR: if (sys_ff.bitcnt == 4'h8) begin
            nxt_sys.bitcnt = 4'h0;
            nxt_sys.sda_oe_n = 1'b0;
            nxt_sys.st = I2C_WR_ACK;
            nxt_sys.ptr = 8'(sys_ff.ptr + 8'h01); // next byte lands one higher
            if (sys_ff.ptr == REG_MODE) begin
              wr0_w = 1'b1;
              nxt_sys.touch0 = 1'b1;
              if (sys_ff.shift[7:MODE_LSB] != sys_ff.regs[REG_MODE][7:MODE_LSB]) begin
                nxt_sys.pcnt = 5'h00;
              end
              nxt_sys.regs[REG_MODE] = (sys_ff.shift & MODE_WMASK) |
                (sys_ff.regs[REG_MODE] & ~MODE_WMASK);
            end else if (sys_ff.ptr < 8'(NUM_REGS) && sys_ff.ptr != REG_DATA_LO &&
                         sys_ff.ptr != REG_DATA_HI) begin
              nxt_sys.regs[sys_ff.ptr[2:0]] = sys_ff.shift;
            end
          end
          I2C_RD: if (sys_ff.bitcnt == 4'h8) begin
            nxt_sys.sda_oe_n = 1'b1;
            nxt_sys.st = I2C_RD_ACK;
          end else begin
            nxt_sys.shift = {sys_ff.shift[6:0], 1'b1};
            nxt_sys.sda_oe_n = sys_ff.shift[6];
          end
          I2C_ADDR_ACK: begin
            nxt_sys.sda_oe_n = 1'b1;
            nxt_sys.st = I2C_PTR;
            load = sys_ff.rw;
          end
          I2C_PTR_ACK, I2C_WR_ACK: begin
            nxt_sys.sda_oe_n = 1'b1;
            nxt_sys.st = I2C_WR;
          end
          I2C_RD_ACK: begin
            nxt_sys.st = I2C_IDLE;
            load = !sys_ff.nack;
          end
          default: begin
            nxt_sys.st = I2C_IDLE;
          end
        endcase
      end
      // open-drain data: releasing the line sends a one
      if (load) begin
        nxt_sys.shift = rd_reg(sys_ff, sys_ff.ptr);
        nxt_sys.sda_oe_n = nxt_sys.shift[7];
        nxt_sys.ptr = 8'(sys_ff.ptr + 8'h01);
        nxt_sys.touch0 = sys_ff.touch0 || (sys_ff.ptr == REG_MODE);
        nxt_sys.bitcnt = 4'h0;
        nxt_sys.st = I2C_RD;
      end
    end

    // a finished conversion counts only if the mode did not change meanwhile
    nxt_sys.done_q = sys_s[0];
    if (ev_done_w) begin
      nxt_sys.busy = 1'b0;
      if (nxt_sys.regs[REG_MODE][7:MODE_LSB] == sys_ff.conv_mode) begin
        val = osc_ff.result & res_mask(sys_ff.conv_res);
        sgn = sys_ff.regs[REG_CFG][SCHEME_BIT] && (sys_ff.conv_mode[1:0] == 2'h3);
        if (sgn && val[res_msb(sys_ff.conv_res)]) begin
          val = val | ~res_mask(sys_ff.conv_res); // sign extension
        end
        nxt_sys.regs[REG_DATA_LO] = val[7:0]; // newest result overwrites
        nxt_sys.regs[REG_DATA_HI] = val[15:8];
        thr_lo = {sys_ff.regs[REG_TLO_HI], sys_ff.regs[REG_TLO_LO]};
        thr_hi = {sys_ff.regs[REG_THI_HI], sys_ff.regs[REG_THI_LO]};
        if (sgn) begin
          out_win = ($signed(val) > $signed(thr_hi)) || ($signed(val) < $signed(thr_lo));
        end else begin
          out_win = (val > thr_hi) || (val < thr_lo);
        end
        if (out_win) begin
          pc = (sys_ff.pcnt < PERSIST_SAT) ? 5'(sys_ff.pcnt + 5'h01) : sys_ff.pcnt;
          nxt_sys.pcnt = pc;
          set_w = pc >= persist_cycles(sys_ff.regs[REG_MODE][PRST_LSB +: 2]);
        end else begin
          nxt_sys.pcnt = 5'h00;
        end
        if (!sys_ff.conv_mode[2]) begin
          nxt_sys.regs[REG_MODE][7:MODE_LSB] = MODE_OFF; // one-shot powers down
        end
      end
    end
    // a new event wins over a clear in the same cycle
    if (set_w) begin
      nxt_sys.regs[REG_MODE][FLAG_BIT] = 1'b1;
    end
    // power-down simply stops issuing requests
    if (!nxt_sys.busy && mode_active(nxt_sys.regs[REG_MODE][7:MODE_LSB])) begin
      nxt_sys.busy = 1'b1;
      nxt_sys.req_tgl = !sys_ff.req_tgl;
      nxt_sys.conv_mode = nxt_sys.regs[REG_MODE][7:MODE_LSB];
      nxt_sys.conv_res = nxt_sys.regs[REG_CFG][RES_LSB +: 2];
    end

    // modulation divider runs freely so the led edges stay regular
    if (sys_ff.mod_cnt == MOD_W'(MOD_HALF_CYC - 1)) begin
      nxt_sys.mod_cnt = '0;
      nxt_sys.mod_ph = !sys_ff.mod_ph;
    end else begin
      nxt_sys.mod_cnt = MOD_W'(sys_ff.mod_cnt + 1'b1);
    end
    nxt_sys.ir_drv = nxt_sys.busy && (nxt_sys.conv_mode[1:0] == 2'h3) &&
      (!nxt_sys.regs[REG_CFG][FREQ_BIT] || nxt_sys.mod_ph);
    nxt_sys.int_oe_n = !nxt_sys.regs[REG_MODE][FLAG_BIT];
  end

  always_ff @(posedge sys_clk_in or negedge rst_ok) begin
    if (!rst_ok) begin
      sys_ff <= '0; // powered down, results zero
      sys_ff.regs[REG_MODE] <= MODE_RST;
      sys_ff.regs[REG_CFG] <= CFG_RST;
      sys_ff.regs[REG_DATA_LO] <= DATA_RST;
      sys_ff.regs[REG_DATA_HI] <= DATA_RST;
      sys_ff.regs[REG_TLO_LO] <= TLO_RST;
      sys_ff.regs[REG_TLO_HI] <= TLO_RST;
      sys_ff.regs[REG_THI_LO] <= THI_RST;
      sys_ff.regs[REG_THI_HI] <= THI_RST;
      sys_ff.st <= I2C_IDLE;
      sys_ff.sda_oe_n <= 1'b1;
      sys_ff.int_oe_n <= 1'b1;
      sys_ff.scl_q <= 1'b1;
      sys_ff.sda_q <= 1'b1;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // integration counter on the oscillator; result held until the next conversion ends
  always_comb begin
    nxt_osc = osc_ff;
    nxt_osc.req_q = req_s;
    if (req_s != osc_ff.req_q) begin
      nxt_osc.run = 1'b1;
      nxt_osc.cnt = 16'h0000;
      nxt_osc.res = sys_ff.conv_res; // stable since the toggle left
    end else if (osc_ff.run) begin
      if (osc_ff.cnt == res_mask(osc_ff.res)) begin
        nxt_osc.run = 1'b0; // 2^n cycles done
        nxt_osc.result = adc_data_in;
        nxt_osc.done_tgl = !osc_ff.done_tgl;
      end else begin
        nxt_osc.cnt = 16'(osc_ff.cnt + 16'h0001);
      end
    end
  end

  always_ff @(posedge osc_clk_in or negedge rst_osc_ok) begin
    if (!rst_osc_ok) begin
      osc_ff <= '0;
    end else begin
      osc_ff <= nxt_osc;
    end
  end

  assign sda_out_out = sys_ff.zero;
  assign sda_oe_n_out = sys_ff.sda_oe_n;
  assign int_out_out = sys_ff.zero;
  assign int_oe_n_out = sys_ff.int_oe_n;
  assign ir_led_drive_out = sys_ff.ir_drv;
  assign ir_led_amp_out = sys_ff.regs[REG_CFG][AMP_LSB +: 2];
  assign sense_range_out = sys_ff.regs[REG_CFG][RANGE_LSB +: 2];
  assign adc_integrate_out = osc_ff.run;

  property p_data_hold;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    !ev_done_w |=> $stable(sys_ff.regs[REG_DATA_HI:REG_DATA_LO]);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("result changed without conversion");

  property p_oneshot_off;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    ev_done_w && !wr0_w && !sys_ff.conv_mode[2] && sys_ff.conv_mode != MODE_OFF &&
      sys_ff.regs[REG_MODE][7:MODE_LSB] == sys_ff.conv_mode
      |=> sys_ff.regs[REG_MODE][7:MODE_LSB] == MODE_OFF ##1 !sys_ff.busy;
  endproperty
  a_oneshot_off: assert property (p_oneshot_off) else $error("one-shot did not power down");

  property p_cont_restart;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    ev_done_w && mode_active(nxt_sys.regs[REG_MODE][7:MODE_LSB])
      |=> sys_ff.busy && (sys_ff.req_tgl != $past(sys_ff.req_tgl));
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("continuous not restarted");

  property p_off_idle;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    !sys_ff.busy && sys_ff.regs[REG_MODE][7:MODE_LSB] == MODE_OFF && !wr0_w
      |=> !sys_ff.busy && $stable(sys_ff.req_tgl);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("conversion while powered down");

  property p_ir_led;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    ir_led_drive_out |-> sys_ff.busy && sys_ff.conv_mode[1:0] == 2'h3;
  endproperty
  a_ir_led: assert property (p_ir_led) else $error("led on outside proximity");

  property p_int_pin;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    $rose(sys_ff.regs[REG_MODE][FLAG_BIT]) |-> !int_oe_n_out ##1 !int_oe_n_out;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("pin does not follow flag");

  property p_flag_hold;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    sys_ff.regs[REG_MODE][FLAG_BIT] && !(stop_w && sys_ff.touch0)
      |=> sys_ff.regs[REG_MODE][FLAG_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");

  property p_flag_clear;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    stop_w && sys_ff.touch0 && !set_w |=> !sys_ff.regs[REG_MODE][FLAG_BIT] && int_oe_n_out;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared at stop");

  property p_addr_miss;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    sys_ff.st == I2C_ADDR && scl_fall_w && !start_w && !stop_w && sys_ff.bitcnt == 4'h8 &&
      sys_ff.shift[7:1] != SLAVE_ADDR |=> sda_oe_n_out && sys_ff.st == I2C_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("acked foreign address");

  property p_persist;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    $rose(sys_ff.regs[REG_MODE][FLAG_BIT])
      |-> sys_ff.pcnt >= persist_cycles(sys_ff.regs[REG_MODE][1:0]);
  endproperty
  a_persist: assert property (p_persist) else $error("flag before persistence met");

  property p_mode_pcnt;
    @(posedge sys_clk_in) disable iff (!rst_ok)
    wr0_w && sys_ff.shift[7:MODE_LSB] != sys_ff.regs[REG_MODE][7:MODE_LSB]
      |=> sys_ff.pcnt == 5'h00;
  endproperty
  a_mode_pcnt: assert property (p_mode_pcnt) else $error("persistence kept over mode change");

  property p_integ;
    @(posedge osc_clk_in) disable iff (!rst_osc_ok)
    osc_ff.run && osc_ff.req_q == req_s && osc_ff.cnt == res_mask(osc_ff.res)
      |=> !osc_ff.run && osc_ff.done_tgl != $past(osc_ff.done_tgl);
  endproperty
  a_integ: assert property (p_integ) else $error("integration length wrong");
endmodule
`default_nettype wire

// ---- bench/lpsc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// i2c master; each phase waits 12 clocks so data never moves near an scl edge
module lpsc_host
  import lpsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic ph();
    repeat (12) @(posedge clk_in);
  endtask
  // also a repeated start when entered with scl low
  task automatic start();
    ph();
    sda_out <= 1'b1;
    ph();
    scl_out <= 1'b1;
    ph();
    sda_out <= 1'b0;
    ph();
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    ph();
    sda_out <= 1'b0;
    ph();
    scl_out <= 1'b1;
    ph();
    sda_out <= 1'b1;
    ph();
  endtask
  // drive b, return the resolved line while scl is high
  task automatic bit_io(input logic b, output logic r);
    ph();
    sda_out <= b;
    ph();
    scl_out <= 1'b1;
    ph();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] b, input logic k, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(k, a);
  endtask
  // n bytes from ptr p, low byte first; ok is 1 when every byte was acked
  task automatic wr(input logic [6:0] sa, input logic [7:0] p, input logic [63:0] d,
                    input int n, output logic ok);
    logic [7:0] r;
    logic a;
    start();
    byte_io({sa, 1'b0}, 1'b1, r, a);
    ok = !a;
    byte_io(p, 1'b1, r, a);
    ok &= !a;
    for (int i = 0; i < n; i++) begin
      byte_io(d[8*i +: 8], 1'b1, r, a);
      ok &= !a;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n, output logic [63:0] d);
    logic [7:0] r;
    logic a;
    d = '0;
    start();
    byte_io({SLAVE_ADDR, 1'b0}, 1'b1, r, a);
    byte_io(p, 1'b1, r, a);
    start();
    byte_io({SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hFF, i == n - 1, r, a);
      d[8*i +: 8] = r;
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ---- bench/test_light_proximity_sense_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_light_proximity_sense_control
  import lpsc_pkg::*;
;
  logic clk = 1'b0;
  logic osc = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] adc = 16'h0000;
  logic scl, host_sda, sda_o, sda_oe_n, int_o, int_oe_n, led, integ, ok;
  logic [1:0] amp, rng;
  logic [63:0] rv;
  wire logic sda;
  int miscompares = 0;
  int samples_checked = 0;
  // pulled-up line, low when either side pulls
  assign sda = host_sda & (sda_oe_n | sda_o);
  always #2 clk = ~clk;
  initial begin
    #7;
    forever #15 osc = ~osc;
  end
  lpsc_top uut (.sys_clk_in(clk), .rst_n_in(rst_n), .osc_clk_in(osc), .scl_in(scl),
    .sda_in(sda), .adc_data_in(adc), .sda_out_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .int_out_out(int_o), .int_oe_n_out(int_oe_n), .ir_led_drive_out(led),
    .ir_led_amp_out(amp), .sense_range_out(rng), .adc_integrate_out(integ));
  lpsc_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(host_sda));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded count of conversion ends, then time for the result to land
  task automatic falls(input int n);
    int k = 0;
    logic p;
    p = integ;
    for (int t = 0; t < 20000 && k < n; t++) begin
      @(posedge clk);
      if (p && !integ) k++;
      p = integ;
    end
    chk(k[15:0], n[15:0]);
    repeat (12) @(posedge clk);
  endtask
  // power-down: let a running conversion end, then no new one may start
  task automatic quiet();
    int k = 0;
    host.wr(SLAVE_ADDR, 8'h00, 64'h0, 1, ok);
    repeat (200) @(posedge clk);
    for (int t = 0; t < 400; t++) begin
      @(posedge clk);
      if (integ || led) k++;
    end
    chk(k[15:0], 16'h0000);
  endtask
  task automatic t_reset();
    chk({int_o, int_oe_n, led, integ}, 16'h0004);
    host.rd(8'h00, 8, rv);
    for (int i = 0; i < 4; i++) chk(rv[16*i +: 16], i == 3 ? 16'hFFFF : 16'h0000);
  endtask
  task automatic t_addr();
    host.wr(7'h45, 8'h00, 64'hA0, 1, ok);
    chk(ok, 1'b0);
    host.wr(SLAVE_ADDR, 8'h04, 64'h1234, 2, ok);
    chk(ok, 1'b1);
    host.rd(8'h00, 6, rv);
    chk(rv[7:0], 8'h00);
    chk(rv[47:32], 16'h1234);
  endtask
  // one-shot light, then infrared, at 4-bit width; both lie below the low threshold 1234
  task automatic t_once();
    host.wr(SLAVE_ADDR, 8'h01, 64'h0C, 1, ok);
    for (int m = 1; m <= 2; m++) begin
      adc <= 16'hABCC + 16'(m);
      host.wr(SLAVE_ADDR, 8'h00, 64'(m << 5), 1, ok);
      falls(1);
      host.rd(8'h00, 4, rv);
      chk(rv[7:0], 8'h04);
      chk(rv[31:16], 16'(12 + m));
      chk(integ, 1'b0);
    end
  endtask
  // continuous light, persistence four; flag must outlive unrelated transfers
  task automatic t_persist();
    adc <= 16'h0003;
    host.wr(SLAVE_ADDR, 8'h04, 64'h0005_0000, 4, ok); // window 0 to 5
    host.wr(SLAVE_ADDR, 8'h00, 64'hA1, 1, ok);
    falls(2);
    adc <= 16'h001F;
    falls(3);
    chk(int_oe_n, 1'b1);
    falls(1);
    chk(int_oe_n, 1'b0);
    host.rd(8'h02, 2, rv);
    chk(rv[15:0], 16'h000F);
    chk(int_oe_n, 1'b0);
    adc <= 16'h0003;
    falls(2);
    host.rd(8'h00, 1, rv);
    chk(rv[7:0], 8'hA5);
    falls(1);
    chk(int_oe_n, 1'b1);
    quiet();
  endtask
  // signed proximity: code C is -4, inside [-8, 5], so no flag
  task automatic t_prox();
    adc <= 16'h000C;
    host.wr(SLAVE_ADDR, 8'h01, 64'h0000_05FF_F800_00BD, 7, ok);
    host.wr(SLAVE_ADDR, 8'h00, 64'hE0, 1, ok);
    falls(1);
    for (int t = 0; t < 400 && !integ; t++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(led, 1'b1);
    chk({amp, rng}, 16'h000D);
    falls(1);
    chk(int_oe_n, 1'b1);
    host.rd(8'h02, 2, rv);
    chk(rv[15:0], 16'hFFFC);
    quiet();
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    t_reset();
    t_addr();
    t_once();
    t_persist();
    t_prox();
    end_sim();
  end
  // watchdog at 75k clocks, about twice the expected run
  initial begin
    #300000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
